// *** hdl/rx_status_pkg.sv ***
// constants for the per-port serializer status and parity error counter registers
// assumes byte-wide register accesses issued by an i2c target engine outside this block
package rx_status_pkg;

  // register offsets
  localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
  localparam logic [7:0] STATUS_BYTE1_ADDR = 8'h52;
  localparam logic [7:0] STATUS_BYTE2_ADDR = 8'h53;
  localparam logic [7:0] STATUS_BYTE3_ADDR = 8'h54;
  localparam logic [7:0] PARITY_HIGH_ADDR = 8'h55;
  localparam logic [7:0] PARITY_LOW_ADDR = 8'h56;

  // port select field: read-port number in the low bits
  localparam int PORT_SEL_W = 2;
  localparam int PORT_SEL_LSB = 0;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] PARITY_COUNT_RESET = 16'h0000;
  localparam logic [PORT_SEL_W-1:0] PORT_SEL_RESET = 2'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // counter ceiling: the count sticks here instead of wrapping
  localparam logic [15:0] PARITY_COUNT_MAX = 16'hFFFF;

  // number of receive ports
  localparam int RX_PORTS = 4;

endpackage

// *** hdl/rx_port_regs.sv ***
// one receive port's copy of the status bytes and the 16-bit parity error counter
// assumes all inputs come from logic on clk; the parent decodes register reads
`timescale 1ns/10ps
module rx_port_regs
  import rx_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // forward channel status
  input wire logic stat_load,
  input wire logic [7:0] stat_b1,
  input wire logic [7:0] stat_b2,
  input wire logic [7:0] stat_b3,
  // link monitoring
  input wire logic par_err,
  input wire logic lock_valid,
  input wire logic check_en,
  // register side
  input wire logic count_clear,
  output logic [7:0] status1_ff,
  output logic [7:0] status2_ff,
  output logic [7:0] status3_ff,
  output logic [15:0] count_ff
);

  ////////////////////////////////////////////////////////////////////////////////
  logic lock_d_ff;
  logic lock_rise;
  logic [15:0] nxt_count;

  // previous lock level for the edge detector; resets high so that a lock
  // already present when reset ends is not seen as a fresh edge
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_d_ff <= 1'b1;
    end else begin
      lock_d_ff <= lock_valid;
    end
  end

  assign lock_rise = lock_valid & ~lock_d_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // status bytes follow the forward channel, read-only to the host
  always_ff @(posedge clk) begin
    if (rst) begin
      status1_ff <= STATUS_RESET;
      status2_ff <= STATUS_RESET;
      status3_ff <= STATUS_RESET;
    end else if (stat_load) begin
      status1_ff <= stat_b1;
      status2_ff <= stat_b2;
      status3_ff <= stat_b3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // restart on new lock or low-byte read; an error in the same cycle still counts
  always_comb begin
    nxt_count = count_ff;
    if (lock_rise || count_clear) begin
      nxt_count = PARITY_COUNT_RESET;
    end
    if (par_err && check_en && nxt_count != PARITY_COUNT_MAX) begin
      nxt_count = nxt_count + 16'h0001;
    end
  end

  // clear-on-read of the low byte wipes both halves
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= PARITY_COUNT_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule // rx_port_regs

// *** hdl/rx_port_status_parity_counters.sv ***
// per-port serializer status bytes and parity error counters behind a byte register port
// assumes an i2c target engine on clk delivers one-cycle read and write strobes
`timescale 1ns/10ps
module rx_port_status_parity_counters
  import rx_status_pkg::*;
#(
  parameter int PORTS = RX_PORTS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access from the i2c target
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  output logic [PORT_SEL_W-1:0] port_sel_ff,
  // forward channel status, one lane per port
  input wire logic [PORTS-1:0] stat_load,
  input wire logic [PORTS*8-1:0] stat_byte1,
  input wire logic [PORTS*8-1:0] stat_byte2,
  input wire logic [PORTS*8-1:0] stat_byte3,
  // link monitoring, one lane per port except parity_check_en, which all ports share
  input wire logic [PORTS-1:0] par_err,
  input wire logic [PORTS-1:0] lock_valid,
  input wire logic parity_check_en
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] st1_w [PORTS];
  logic [7:0] st2_w [PORTS];
  logic [7:0] st3_w [PORTS];
  logic [15:0] cnt_w [PORTS];
  logic [PORTS-1:0] clr_w;
  logic [7:0] sel_st1;
  logic [7:0] sel_st2;
  logic [7:0] sel_st3;
  logic [15:0] sel_cnt;
  logic [7:0] nxt_rdata;

  // true when the access addresses the given register
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_off);
    hit = (addr == reg_off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // port select: written by the host, also readable back
  always_ff @(posedge clk) begin
    if (rst) begin
      port_sel_ff <= PORT_SEL_RESET;
    end else if (reg_wr && hit(reg_addr, PORT_SELECT_ADDR)) begin
      port_sel_ff <= reg_wdata[PORT_SEL_LSB +: PORT_SEL_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one register copy per port; only the selected port sees the read-clear
  generate
    for (genvar p = 0; p < PORTS; p++) begin : g_port
      assign clr_w[p] = reg_rd && hit(reg_addr, PARITY_LOW_ADDR)
                        && (port_sel_ff == PORT_SEL_W'(p));
      rx_port_regs u_regs (
        .clk(clk),
        .rst(rst),
        .stat_load(stat_load[p]),
        .stat_b1(stat_byte1[p*8 +: 8]),
        .stat_b2(stat_byte2[p*8 +: 8]),
        .stat_b3(stat_byte3[p*8 +: 8]),
        .par_err(par_err[p]),
        .lock_valid(lock_valid[p]),
        .check_en(parity_check_en),
        .count_clear(clr_w[p]),
        .status1_ff(st1_w[p]),
        .status2_ff(st2_w[p]),
        .status3_ff(st3_w[p]),
        .count_ff(cnt_w[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // route the selected port's copy; a select beyond the port count reads zero
  always_comb begin
    sel_st1 = STATUS_RESET;
    sel_st2 = STATUS_RESET;
    sel_st3 = STATUS_RESET;
    sel_cnt = PARITY_COUNT_RESET;
    for (int i = 0; i < PORTS; i++) begin
      if (port_sel_ff == PORT_SEL_W'(i)) begin
        sel_st1 = st1_w[i];
        sel_st2 = st2_w[i];
        sel_st3 = st3_w[i];
        sel_cnt = cnt_w[i];
      end
    end
  end

  // read mux; the low byte is captured before its clear lands
  always_comb begin
    nxt_rdata = UNMAPPED_READ;
    case (reg_addr)
      PORT_SELECT_ADDR: nxt_rdata = {{(8-PORT_SEL_W){1'b0}}, port_sel_ff};
      STATUS_BYTE1_ADDR: nxt_rdata = sel_st1;
      STATUS_BYTE2_ADDR: nxt_rdata = sel_st2;
      STATUS_BYTE3_ADDR: nxt_rdata = sel_st3;
      PARITY_HIGH_ADDR: nxt_rdata = sel_cnt[15:8];
      PARITY_LOW_ADDR: nxt_rdata = sel_cnt[7:0];
      default: nxt_rdata = UNMAPPED_READ;
    endcase
  end

  // read data held until the next read; writes to read-only bytes are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= UNMAPPED_READ;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] cnt0;
  logic lock0_d;
  assign cnt0 = cnt_w[0];

  // mirrors the port's edge detector, including its high reset value
  always_ff @(posedge clk) begin
    if (rst) begin
      lock0_d <= 1'b1;
    end else begin
      lock0_d <= lock_valid[0];
    end
  end

  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  sequence s_port0_quiet;
    !par_err[0] && !(lock_valid[0] && !lock0_d);
  endsequence

  property p_route_select;
    @(posedge clk) disable iff (rst)
      s_read(PARITY_LOW_ADDR) |=> reg_rvalid_ff && reg_rdata_ff == $past(sel_cnt[7:0]);
  endproperty
  a_route_select: assert property (p_route_select) else $error("low byte not from selected port");

  property p_status_load;
    @(posedge clk) disable iff (rst)
      stat_load[0] |=> st1_w[0] == $past(stat_byte1[7:0]) && st2_w[0] == $past(stat_byte2[7:0]);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status bytes not loaded");

  property p_status3_read;
    @(posedge clk) disable iff (rst)
      s_read(STATUS_BYTE3_ADDR) ##0 !stat_load[0] ##0 port_sel_ff == 2'h0
      |=> reg_rdata_ff == st3_w[0];
  endproperty
  a_status3_read: assert property (p_status3_read) else $error("status byte three misread");

  property p_count_up;
    @(posedge clk) disable iff (rst)
      par_err[0] && parity_check_en && !clr_w[0] && !(lock_valid[0] && !lock0_d)
      && cnt0 != PARITY_COUNT_MAX |=> cnt0 == $past(cnt0) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("parity error not counted");

  property p_high_read;
    @(posedge clk) disable iff (rst)
      s_read(PARITY_HIGH_ADDR) |=> reg_rdata_ff == $past(sel_cnt[15:8]);
  endproperty
  a_high_read: assert property (p_high_read) else $error("high byte misread");

  property p_high_no_clear;
    @(posedge clk) disable iff (rst)
      s_read(PARITY_HIGH_ADDR) ##0 s_port0_quiet |=> cnt0 == $past(cnt0);
  endproperty
  a_high_no_clear: assert property (p_high_no_clear) else $error("high read changed count");

  property p_reset_zero;
    @(posedge clk)
      rst |=> cnt0 == PARITY_COUNT_RESET && st1_w[0] == STATUS_RESET
              && st3_w[0] == STATUS_RESET && reg_rdata_ff == UNMAPPED_READ;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

  property p_low_clear;
    @(posedge clk) disable iff (rst)
      s_read(PARITY_LOW_ADDR) ##0 port_sel_ff == 2'h0 ##0 s_port0_quiet
      |=> cnt0 == PARITY_COUNT_RESET ##1 (cnt0 <= 16'h0001);
  endproperty
  a_low_clear: assert property (p_low_clear) else $error("low read did not clear");

  property p_lock_restart;
    @(posedge clk) disable iff (rst)
      lock_valid[0] && !lock0_d && !par_err[0] |=> cnt0 == PARITY_COUNT_RESET;
  endproperty
  a_lock_restart: assert property (p_lock_restart) else $error("lock did not restart count");

  property p_select_write;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == PORT_SELECT_ADDR
      |=> port_sel_ff == $past(reg_wdata[PORT_SEL_LSB +: PORT_SEL_W]);
  endproperty
  a_select_write: assert property (p_select_write) else $error("port select not stored");

  property p_status_read_only;
    @(posedge clk) disable iff (rst)
      reg_wr && !stat_load[0] |=> st1_w[0] == $past(st1_w[0]) && st3_w[0] == $past(st3_w[0]);
  endproperty
  a_status_read_only: assert property (p_status_read_only) else $error("status changed by write");

  property p_count_paused;
    @(posedge clk) disable iff (rst)
      !parity_check_en && !clr_w[0] && !(lock_valid[0] && !lock0_d) |=> cnt0 == $past(cnt0);
  endproperty
  a_count_paused: assert property (p_count_paused) else $error("count moved with checker off");

  property p_read_answer;
    @(posedge clk) disable iff (rst)
      reg_rd |=> reg_rvalid_ff;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read got no answer");

  property p_no_stray_answer;
    @(posedge clk) disable iff (rst)
      !reg_rd |=> !reg_rvalid_ff;
  endproperty
  a_no_stray_answer: assert property (p_no_stray_answer) else $error("answer without read");

endmodule // rx_port_status_parity_counters

// *** verification/serializer_model.sv ***
// remote serializer model: forward channel status bytes, parity errors and lock, per port
// assumes the bench calls its tasks one at a time; lanes change only at falling edges
`timescale 1ns/10ps
module serializer_model
  import rx_status_pkg::*;
#(
  parameter int PORTS = RX_PORTS
) (
  // clock
  input wire logic clk,
  // forward channel lanes
  output logic [PORTS-1:0] stat_load,
  output logic [PORTS*8-1:0] stat_byte1,
  output logic [PORTS*8-1:0] stat_byte2,
  output logic [PORTS*8-1:0] stat_byte3,
  // link events
  output logic [PORTS-1:0] par_err,
  output logic [PORTS-1:0] lock_valid
);
  ////////////////////////////////////////////////////////////////////////////////////////////
  // idle lanes, link already locked
  initial begin
    stat_load = '0;
    stat_byte1 = '0;
    stat_byte2 = '0;
    stat_byte3 = '0;
    par_err = '0;
    lock_valid = '1;
  end

  // one load pulse; bytes flip afterwards so a late sample cannot pass by luck
  task automatic send_status(input int p, input logic [7:0] b1, b2, b3);
    @(negedge clk);
    stat_load[p] = 1'b1;
    stat_byte1[p*8+:8] = b1;
    stat_byte2[p*8+:8] = b2;
    stat_byte3[p*8+:8] = b3;
    @(negedge clk);
    stat_load[p] = 1'b0;
    stat_byte1[p*8+:8] = ~b1;
    stat_byte2[p*8+:8] = ~b2;
    stat_byte3[p*8+:8] = ~b3;
  endtask

  // n back-to-back error cycles
  task automatic send_errors(input int p, input int n);
    repeat (n) begin
      @(negedge clk);
      par_err[p] = 1'b1;
    end
    @(negedge clk);
    par_err[p] = 1'b0;
  endtask

  // lock drops for one cycle and comes back
  task automatic relock(input int p);
    @(negedge clk);
    lock_valid[p] = 1'b0;
    @(negedge clk);
    lock_valid[p] = 1'b1;
  endtask
endmodule // serializer_model

// *** verification/tb.sv ***
// self-checking bench for the per-port status and parity counter registers
// assumes the register port contract: one-cycle strobes, read answer one cycle later
`timescale 1ns/10ps
module tb;
  import rx_status_pkg::*;
  localparam int PORTS = RX_PORTS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic parity_check_en = 1'b1;
  logic [7:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  logic [PORT_SEL_W-1:0] port_sel_ff;
  logic [PORTS-1:0] stat_load, par_err, lock_valid;
  logic [PORTS*8-1:0] stat_byte1, stat_byte2, stat_byte3;
  int errors = 0;
  int total_checks = 0;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // 8 ns clock
  always #4 clk = ~clk;

  rx_port_status_parity_counters #(.PORTS(PORTS)) rx_port_status_parity_counters_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .port_sel_ff(port_sel_ff), .stat_load(stat_load), .stat_byte1(stat_byte1),
    .stat_byte2(stat_byte2), .stat_byte3(stat_byte3), .par_err(par_err),
    .lock_valid(lock_valid), .parity_check_en(parity_check_en));

  serializer_model #(.PORTS(PORTS)) serializer_model_inst (
    .clk(clk), .stat_load(stat_load), .stat_byte1(stat_byte1), .stat_byte2(stat_byte2),
    .stat_byte3(stat_byte3), .par_err(par_err), .lock_valid(lock_valid));

  ////////////////////////////////////////////////////////////////////////////////////////////
  // compare, access tasks and verdict
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // answer is taken in the cycle after the strobe, bounded in case it never comes
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    while (reg_rvalid_ff !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk8({what, " valid"}, 8'h01, {7'h00, reg_rvalid_ff});
    chk8(what, exp, reg_rdata_ff);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int a = 0; a < 5; a++) expect_reg("reset byte", STATUS_BYTE1_ADDR + 8'(a), 8'h00);
    for (int p = 0; p < PORTS; p++)
      serializer_model_inst.send_status(p, 8'h10 + 8'(p), 8'h20 + 8'(p), 8'h30 + 8'(p));
    for (int p = 0; p < PORTS; p++) begin
      reg_write(PORT_SELECT_ADDR, 8'(p));
      expect_reg("port select", PORT_SELECT_ADDR, 8'(p));
      expect_reg("status1", STATUS_BYTE1_ADDR, 8'h10 + 8'(p));
      expect_reg("status2", STATUS_BYTE2_ADDR, 8'h20 + 8'(p));
      expect_reg("status3", STATUS_BYTE3_ADDR, 8'h30 + 8'(p));
    end
    // read-only write ignored, unmapped read gives zero
    reg_write(STATUS_BYTE1_ADDR, 8'hA5);
    expect_reg("status1 after write", STATUS_BYTE1_ADDR, 8'h13);
    expect_reg("unmapped", 8'h57, UNMAPPED_READ);
    // small count; errors with the checker off are not counted
    reg_write(PORT_SELECT_ADDR, 8'h01);
    serializer_model_inst.send_errors(1, 3);
    @(negedge clk) parity_check_en = 1'b0;
    serializer_model_inst.send_errors(1, 2);
    expect_reg("count high", PARITY_HIGH_ADDR, 8'h00);
    expect_reg("count low", PARITY_LOW_ADDR, 8'h03);
    expect_reg("count low again", PARITY_LOW_ADDR, 8'h00);
    // count past one byte on port 2, a few on port 0
    @(negedge clk) parity_check_en = 1'b1;
    serializer_model_inst.send_errors(2, 300);
    serializer_model_inst.send_errors(0, 5);
    @(negedge clk) parity_check_en = 1'b0;
    reg_write(PORT_SELECT_ADDR, 8'h02);
    expect_reg("wide high", PARITY_HIGH_ADDR, 8'h01);
    expect_reg("wide high reread", PARITY_HIGH_ADDR, 8'h01);
    expect_reg("wide low", PARITY_LOW_ADDR, 8'h2C);
    expect_reg("wide high cleared", PARITY_HIGH_ADDR, 8'h00);
    reg_write(PORT_SELECT_ADDR, 8'h00);
    expect_reg("port0 low", PARITY_LOW_ADDR, 8'h05);
    // new lock restarts the count
    @(negedge clk) parity_check_en = 1'b1;
    serializer_model_inst.send_errors(3, 2);
    serializer_model_inst.send_errors(0, 4);
    serializer_model_inst.relock(0);
    serializer_model_inst.send_errors(0, 1);
    @(negedge clk) parity_check_en = 1'b0;
    expect_reg("after relock", PARITY_LOW_ADDR, 8'h01);
    reg_write(PORT_SELECT_ADDR, 8'h03);
    expect_reg("port3 low", PARITY_LOW_ADDR, 8'h02);
    // second reset in mid-run
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk8("select after reset", 8'h00, {6'h00, port_sel_ff});
    expect_reg("status1 after reset", STATUS_BYTE1_ADDR, 8'h00);
    give_verdict();
  end
endmodule // tb
